// ===== spsps_chan.v
`timescale 1ns/10ps
`include "spsps_regs.vh"

module spsps_chan #(
  parameter [15:0] CHAN_INDEX = 16'h0000
) (
  input  wire        ref_clk_in,
  input  wire        rst_n_in,
  input  wire        pkt_valid_in,
  output wire        pkt_ready_out,
  input  wire [7:0]  pkt_data_in,
  input  wire        pkt_last_in,
  input  wire [15:0] pkt_dst_port_in,
  input  wire [31:0] pkt_src_ip_in,
  input  wire [15:0] pkt_src_port_in,
  output wire        resp_valid_out,
  input  wire        resp_ready_in,
  output wire [7:0]  resp_data_out,
  output wire        resp_last_out,
  output wire [31:0] resp_dst_ip_out,
  output wire [15:0] resp_dst_port_out,
  input  wire        rx_char_valid_in,
  input  wire [7:0]  rx_char_in,
  input  wire        rx_frame_err_in,
  input  wire        rx_parity_err_in,
  input  wire        rx_uart_overrun_in,
  input  wire        tx_busy_in,
  output wire        tx_char_valid_out,
  input  wire        tx_char_ready_in,
  output wire [7:0]  tx_char_out,
  output wire        tx_driver_en_out,
  output wire        rx_enable_out,
  output wire        port_open_out,
  output wire [7:0]  status_out,
  output wire [15:0] mode_clock_div_out,
  output wire [7:0]  mode_attrib_out,
  output wire [7:0]  mode_leds_out
);

  // ========================================================================
  // State and registers
  // ========================================================================
  localparam [2:0] S_IDLE = 3'd0;
  localparam [2:0] S_SKIP = 3'd1;
  localparam [2:0] S_DATA = 3'd2;
  localparam [2:0] S_EXEC = 3'd3;
  localparam [2:0] S_RESP = 3'd4;

  reg  [2:0]  state_q;
  reg  [2:0]  state_d;
  reg         pkt_ready_q;
  reg         pkt_ready_d;
  reg  [7:0]  op_q;
  reg  [10:0] nbytes_q;
  reg  [31:0] src_ip_q;
  reg  [15:0] src_port_q;
  reg  [15:0] sh_clkdiv_q;
  reg  [7:0]  sh_attrib_q;
  reg  [7:0]  sh_leds_q;
  reg  [15:0] clkdiv_q;
  reg  [7:0]  attrib_q;
  reg  [7:0]  leds_q;
  reg         rej_q;
  reg         open_q;
  reg         frm_q;
  reg         par_q;
  reg         ovr_q;
  reg  [7:0]  status_q;
  reg         resp_valid_q;
  reg  [7:0]  resp_data_q;
  reg         resp_last_q;
  reg  [6:0]  resp_idx_q;
  reg  [6:0]  resp_last_idx_q;
  reg  [5:0]  rx_snap_q;
  reg         tx_char_valid_q;
  reg  [7:0]  tx_char_q;
  reg         tx_drv_q;
  reg         rx_en_q;
  reg         exec_rej;
  reg  [7:0]  resp_byte;

  wire        pkt_take;
  wire [15:0] own_port;
  wire [1:0]  line_type;
  wire        rx_gate;
  wire        rx_good;
  wire        rx_push;
  wire        rx_lost;
  wire        frm_set;
  wire        par_set;
  wire        ovr_set;
  wire        exec_ok;
  wire        flags_clr;
  wire        tx_push;
  wire        tx_load;
  wire        resp_load;
  wire        resp_done;
  wire        rx_pop;
  wire        rx_flush;
  wire [7:0]  status_now;
  wire [7:0]  tx_total;
  wire        tx_in_ready;
  wire        tx_out_valid;
  wire [7:0]  tx_out_data;
  wire [5:0]  tx_cnt;
  wire        rx_in_ready;
  wire        rx_out_valid;
  wire [7:0]  rx_out_data;
  wire [5:0]  rx_cnt;

  // ========================================================================
  // Buffers
  // ========================================================================
  // Transmit buffer; its fill level throttles packet intake during sends
  spsps_fifo #(
    .WIDTH (8),
    .DEPTH (`SPSPS_FIFO_DEPTH),
    .AW    (`SPSPS_FIFO_AW)
  ) u_tx_fifo (
    .ref_clk_in    (ref_clk_in),
    .rst_n_in      (rst_n_in),
    .flush_in      (1'b0),
    .in_valid_in   (tx_push),
    .in_ready_out  (tx_in_ready),
    .in_data_in    (pkt_data_in),
    .out_valid_out (tx_out_valid),
    .out_ready_in  (tx_load),
    .out_data_out  (tx_out_data),
    .count_out     (tx_cnt)
  );

  // Receive buffer, drained by receive commands
  spsps_fifo #(
    .WIDTH (8),
    .DEPTH (`SPSPS_FIFO_DEPTH),
    .AW    (`SPSPS_FIFO_AW)
  ) u_rx_fifo (
    .ref_clk_in    (ref_clk_in),
    .rst_n_in      (rst_n_in),
    .flush_in      (rx_flush),
    .in_valid_in   (rx_push),
    .in_ready_out  (rx_in_ready),
    .in_data_in    (rx_char_in),
    .out_valid_out (rx_out_valid),
    .out_ready_in  (rx_pop),
    .out_data_out  (rx_out_data),
    .count_out     (rx_cnt)
  );

  // ========================================================================
  // Serial side
  // ========================================================================
  assign pkt_take  = pkt_valid_in & pkt_ready_q;
  assign own_port  = `SPSPS_BASE_UDP_PORT + CHAN_INDEX;
  assign line_type = attrib_q[`SPSPS_LT_MSB:`SPSPS_LT_LSB];

  // Half duplex blinds the receiver while our own transmitter runs
  assign rx_gate = open_q & ~((line_type == `SPSPS_LT_HALF_DUPLEX) & tx_busy_in);
  assign rx_good = rx_char_valid_in & rx_gate & ~rx_frame_err_in & ~rx_parity_err_in;
  assign rx_push = rx_good & rx_in_ready;
  assign rx_lost = rx_good & ~rx_in_ready;
  assign frm_set = rx_char_valid_in & rx_gate & rx_frame_err_in;
  assign par_set = rx_char_valid_in & rx_gate & rx_parity_err_in;
  assign ovr_set = rx_lost | (rx_uart_overrun_in & open_q);

  // Send data goes to the buffer only on an open channel, within the size cap
  assign tx_push = pkt_take & (state_q == S_DATA) & (op_q == `SPSPS_OP_SEND) & open_q
                   & tx_in_ready & (nbytes_q < `SPSPS_MAX_PKT_BYTES);
  // Holding register keeps the character output straight off a flop
  assign tx_load = open_q & tx_out_valid & (~tx_char_valid_q | tx_char_ready_in);
  assign tx_total = {2'b00, tx_cnt} + {7'd0, tx_char_valid_q};

  // ========================================================================
  // Command decision
  // ========================================================================
  // Legality of the one operation carried by the packet
  always @* begin
    case (op_q)
      `SPSPS_OP_SETMODE:      exec_rej = (nbytes_q != `SPSPS_SETMODE_BYTES);
      `SPSPS_OP_SEND:         exec_rej = ~open_q;
      `SPSPS_OP_RECEIVE:      exec_rej = ~open_q;
      `SPSPS_OP_CLEAR_FLAGS:  exec_rej = 1'b0;
      `SPSPS_OP_OPEN:         exec_rej = 1'b0;
      `SPSPS_OP_CLOSE:        exec_rej = 1'b0;
      `SPSPS_OP_FLUSH:        exec_rej = 1'b0;
      `SPSPS_OP_GET_RX_COUNT: exec_rej = 1'b0;
      `SPSPS_OP_GET_TX_COUNT: exec_rej = 1'b0;
      default:                exec_rej = 1'b1;
    endcase
    if (nbytes_q > `SPSPS_MAX_PKT_BYTES) begin
      exec_rej = 1'b1;
    end
  end

  assign exec_ok   = (state_q == S_EXEC) & ~exec_rej;
  assign flags_clr = exec_ok & (op_q == `SPSPS_OP_CLEAR_FLAGS);
  assign rx_flush  = exec_ok & (op_q == `SPSPS_OP_FLUSH);

  // ========================================================================
  // Packet sequencing
  // ========================================================================
  // One packet in, one execute step, one response out
  always @* begin
    state_d = state_q;
    case (state_q)
      S_IDLE: begin
        if (pkt_take) begin
          if (pkt_dst_port_in != own_port) begin
            state_d = pkt_last_in ? S_IDLE : S_SKIP;
          end else begin
            state_d = pkt_last_in ? S_EXEC : S_DATA;
          end
        end
      end
      S_SKIP: begin
        if (pkt_take && pkt_last_in) begin
          state_d = S_IDLE;
        end
      end
      S_DATA: begin
        if (pkt_take && pkt_last_in) begin
          state_d = S_EXEC;
        end
      end
      S_EXEC:  state_d = S_RESP;
      S_RESP: begin
        if (resp_done) begin
          state_d = S_IDLE;
        end
      end
      default: state_d = S_IDLE;
    endcase
  end

  // Ready is registered, so it is judged for the coming state with headroom
  always @* begin
    case (state_d)
      S_IDLE:  pkt_ready_d = 1'b1;
      S_SKIP:  pkt_ready_d = 1'b1;
      // On the opcode byte itself op_q is still stale, so the byte is looked at
      S_DATA:  pkt_ready_d = (((state_q == S_IDLE) ? pkt_data_in : op_q) != `SPSPS_OP_SEND)
                             || (tx_cnt < `SPSPS_TX_READY_LIMIT);
      default: pkt_ready_d = 1'b0;
    endcase
  end

  // ========================================================================
  // Response builder
  // ========================================================================
  assign status_now = {3'b000, ovr_q, par_q, frm_q, open_q, rej_q};
  assign resp_load  = (state_q == S_RESP) & (resp_idx_q <= resp_last_idx_q)
                      & (~resp_valid_q | resp_ready_in);
  assign resp_done  = resp_valid_q & resp_ready_in & resp_last_q;
  assign rx_pop     = resp_load & (op_q == `SPSPS_OP_RECEIVE) & ~rej_q
                      & (resp_idx_q >= 7'd2);

  // Byte for the current response position
  always @* begin
    resp_byte = 8'h00;
    if (resp_idx_q == 7'd0) begin
      resp_byte = status_now;
    end else if (op_q == `SPSPS_OP_GET_RX_COUNT) begin
      resp_byte = (resp_idx_q == 7'd1) ? {2'b00, rx_cnt} : 8'h00;
    end else if (op_q == `SPSPS_OP_GET_TX_COUNT) begin
      resp_byte = (resp_idx_q == 7'd1) ? tx_total : 8'h00;
    end else if (op_q == `SPSPS_OP_RECEIVE) begin
      resp_byte = (resp_idx_q == 7'd1) ? {2'b00, rx_snap_q} : rx_out_data;
    end
  end

  // ========================================================================
  // Registers
  // ========================================================================
  // Sequencer, capture of packet fields and response stream
  always @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      state_q         <= S_IDLE;
      pkt_ready_q     <= 1'b0;
      op_q            <= 8'h00;
      nbytes_q        <= 11'd0;
      src_ip_q        <= 32'h0000_0000;
      src_port_q      <= 16'h0000;
      sh_clkdiv_q     <= 16'h0000;
      sh_attrib_q     <= 8'h00;
      sh_leds_q       <= 8'h00;
      resp_valid_q    <= 1'b0;
      resp_data_q     <= 8'h00;
      resp_last_q     <= 1'b0;
      resp_idx_q      <= 7'd0;
      resp_last_idx_q <= 7'd0;
      rx_snap_q       <= 6'd0;
    end else begin
      state_q     <= state_d;
      pkt_ready_q <= pkt_ready_d;
      if (pkt_take && (state_q == S_IDLE) && (pkt_dst_port_in == own_port)) begin
        op_q       <= pkt_data_in;
        nbytes_q   <= 11'd1;
        src_ip_q   <= pkt_src_ip_in;
        src_port_q <= pkt_src_port_in;
      end else if (pkt_take && (state_q == S_DATA)) begin
        if (nbytes_q != `SPSPS_BYTE_CNT_MAX) begin
          nbytes_q <= nbytes_q + 11'd1;
        end
        case (nbytes_q)
          11'd1:   sh_clkdiv_q[7:0]  <= pkt_data_in;
          11'd2:   sh_clkdiv_q[15:8] <= pkt_data_in;
          11'd3:   sh_attrib_q       <= pkt_data_in;
          11'd4:   sh_leds_q         <= pkt_data_in;
          default: sh_leds_q         <= sh_leds_q;
        endcase
      end
      // Response length fixed at execute; rejection returns status only
      if (state_q == S_EXEC) begin
        resp_idx_q <= 7'd0;
        rx_snap_q  <= rx_cnt;
        if (exec_rej) begin
          resp_last_idx_q <= 7'd0;
        end else if ((op_q == `SPSPS_OP_GET_RX_COUNT) || (op_q == `SPSPS_OP_GET_TX_COUNT)) begin
          resp_last_idx_q <= 7'd2;
        end else if (op_q == `SPSPS_OP_RECEIVE) begin
          resp_last_idx_q <= 7'd1 + {1'b0, rx_cnt};
        end else begin
          resp_last_idx_q <= 7'd0;
        end
      end
      if (resp_load) begin
        resp_valid_q <= 1'b1;
        resp_data_q  <= resp_byte;
        resp_last_q  <= (resp_idx_q == resp_last_idx_q);
        resp_idx_q   <= resp_idx_q + 7'd1;
      end else if (resp_valid_q && resp_ready_in) begin
        resp_valid_q <= 1'b0;
        resp_last_q  <= 1'b0;
      end
    end
  end

  // Channel flags; a hardware set wins over a same-cycle clear
  always @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      rej_q  <= 1'b0;
      open_q <= 1'b0;
      frm_q  <= 1'b0;
      par_q  <= 1'b0;
      ovr_q  <= 1'b0;
    end else begin
      if (pkt_take && (state_q == S_IDLE) && (pkt_dst_port_in == own_port)) begin
        rej_q <= 1'b0;
      end else if (state_q == S_EXEC) begin
        rej_q <= exec_rej;
      end
      if (exec_ok && (op_q == `SPSPS_OP_OPEN)) begin
        open_q <= 1'b1;
      end else if (exec_ok && (op_q == `SPSPS_OP_CLOSE)) begin
        open_q <= 1'b0;
      end
      frm_q <= frm_set | (frm_q & ~flags_clr);
      par_q <= par_set | (par_q & ~flags_clr);
      ovr_q <= ovr_set | (ovr_q & ~flags_clr);
    end
  end

  // Mode, transmit holding register and line control
  always @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      clkdiv_q        <= `SPSPS_CLKDIV_RESET;
      attrib_q        <= `SPSPS_ATTRIB_RESET;
      leds_q          <= `SPSPS_LEDS_RESET;
      tx_char_valid_q <= 1'b0;
      tx_char_q       <= 8'h00;
      tx_drv_q        <= 1'b0;
      rx_en_q         <= 1'b0;
      status_q        <= 8'h00;
    end else begin
      if (exec_ok && (op_q == `SPSPS_OP_SETMODE)) begin
        clkdiv_q <= sh_clkdiv_q;
        attrib_q <= sh_attrib_q;
        leds_q   <= sh_leds_q;
      end
      if (tx_load) begin
        tx_char_valid_q <= 1'b1;
        tx_char_q       <= tx_out_data;
      end else if (tx_char_ready_in) begin
        tx_char_valid_q <= 1'b0;
      end
      // Half duplex and switched full drive only while sending; others keep the driver on
      if (line_type[1]) begin
        tx_drv_q <= tx_busy_in;
      end else begin
        tx_drv_q <= 1'b1;
      end
      rx_en_q  <= rx_gate;
      status_q <= status_now;
    end
  end

  // ========================================================================
  // Outputs
  // ========================================================================
  assign pkt_ready_out      = pkt_ready_q;
  assign resp_valid_out     = resp_valid_q;
  assign resp_data_out      = resp_data_q;
  assign resp_last_out      = resp_last_q;
  assign resp_dst_ip_out    = src_ip_q;
  assign resp_dst_port_out  = src_port_q;
  assign tx_char_valid_out  = tx_char_valid_q;
  assign tx_char_out        = tx_char_q;
  assign tx_driver_en_out   = tx_drv_q;
  assign rx_enable_out      = rx_en_q;
  assign port_open_out      = open_q;
  assign status_out         = status_q;
  assign mode_clock_div_out = clkdiv_q;
  assign mode_attrib_out    = attrib_q;
  assign mode_leds_out      = leds_q;

endmodule // spsps_chan

// ===== spsps_chan_props.sv
`timescale 1ns/10ps
`include "spsps_regs.vh"
// ======================================
// Channel port checks
module spsps_chan_props #(
  parameter [15:0] CHAN_INDEX = 16'h0000
) (
  input wire       ref_clk_in,
  input wire [15:0] pkt_dst_port_in,
  input wire       rst_n_in,
  input wire       pkt_valid_in,
  input wire       pkt_ready_out,
  input wire       pkt_last_in,
  input wire       resp_valid_out,
  input wire       resp_ready_in,
  input wire [7:0] resp_data_out,
  input wire       tx_busy_in,
  input wire       tx_driver_en_out,
  input wire       rx_enable_out,
  input wire       port_open_out,
  input wire [7:0] status_out,
  input wire [7:0] mode_attrib_out
);
  localparam [15:0] OWN_PORT = `SPSPS_BASE_UDP_PORT + CHAN_INDEX;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  // Intake shuts after each packet to this channel's port so only one command runs
  AST_ONE_CMD: assert property (
    pkt_valid_in && pkt_ready_out && pkt_last_in && pkt_dst_port_in == OWN_PORT
    |=> !pkt_ready_out) else $error("intake open");
  AST_BUSY_ANSWER: assert property (resp_valid_out |-> !pkt_ready_out)
    else $error("intake open while answering");
  AST_RESP_HOLD: assert property (
    resp_valid_out && !resp_ready_in |=> resp_valid_out && $stable(resp_data_out))
    else $error("response byte dropped");
  AST_STATUS_SPARE: assert property (status_out[7:5] == 3'b000)
    else $error("spare status bits set");
  AST_OPEN_BY_CMD: assert property ($changed(port_open_out) |-> !pkt_ready_out)
    else $error("open flag moved outside a command");
  // Opcode is not decoded here, so a clear is only tied to a command slot
  AST_ERR_STICKY: assert property (
    ($past(status_out[4:2]) & ~status_out[4:2]) != 3'b000
    |-> !$past(pkt_ready_out) || !$past(pkt_ready_out, 2)) else $error("error flag self-cleared");
  AST_DRV_SENDING: assert property (
    mode_attrib_out[7] && $past(mode_attrib_out[7]) |-> tx_driver_en_out == $past(tx_busy_in))
    else $error("driver enable not following busy");
  AST_RX_BLOCKED: assert property (
    mode_attrib_out[7:6] == 2'b10 && $past(mode_attrib_out[7:6]) == 2'b10 && $past(tx_busy_in)
    |-> !rx_enable_out) else $error("receiver on while sending");
  COV_RESP: cover property (resp_valid_out && resp_ready_in);
  COV_OVR: cover property (status_out[4]);
  COV_DRV_OFF: cover property ($fell(tx_driver_en_out));
endmodule // spsps_chan_props

bind spsps_chan spsps_chan_props #(.CHAN_INDEX(CHAN_INDEX)) u_props (.*);

// ===== spsps_fifo.v
`timescale 1ns/10ps

// ==========================================================================
// Synchronous FIFO with valid/ready on both sides
// ==========================================================================
module spsps_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             ref_clk_in,
  input  wire             rst_n_in,
  input  wire             flush_in,
  input  wire             in_valid_in,
  output wire             in_ready_out,
  input  wire [WIDTH-1:0] in_data_in,
  output wire             out_valid_out,
  input  wire             out_ready_in,
  output wire [WIDTH-1:0] out_data_out,
  output wire [AW:0]      count_out
);

  reg  [WIDTH-1:0] mem [0:DEPTH-1];
  reg  [AW-1:0]    wr_ptr_q;
  reg  [AW-1:0]    rd_ptr_q;
  reg  [AW:0]      count_q;
  wire             push;
  wire             pop;

  // Full and empty come straight from the occupancy count
  assign in_ready_out  = (count_q != DEPTH[AW:0]);
  assign out_valid_out = (count_q != {(AW+1){1'b0}});
  assign out_data_out  = mem[rd_ptr_q];
  assign count_out     = count_q;
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_valid_out & out_ready_in;

  // Storage has no reset; only the pointers and the count need a defined state
  always @(posedge ref_clk_in) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data_in;
    end
  end

  // Pointer and count update; flush wins over a same-cycle transfer
  always @(posedge ref_clk_in) begin
    if (!rst_n_in || flush_in) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

endmodule // spsps_fifo

// ===== spsps_regs.vh
`ifndef SPSPS_REGS_VH
`define SPSPS_REGS_VH

// ==========================================================================
// Channel addressing and packet limits
// ==========================================================================
`define SPSPS_BASE_UDP_PORT     16'd10001
`define SPSPS_MAX_PKT_BYTES     11'd1024
`define SPSPS_SETMODE_BYTES     11'd5
`define SPSPS_BYTE_CNT_MAX      11'h7ff

// ==========================================================================
// Opcodes
// ==========================================================================
`define SPSPS_OP_SETMODE        8'h00
`define SPSPS_OP_SEND           8'h01
`define SPSPS_OP_RECEIVE        8'h02
`define SPSPS_OP_CLEAR_FLAGS    8'h03
`define SPSPS_OP_OPEN           8'h04
`define SPSPS_OP_CLOSE          8'h05
`define SPSPS_OP_FLUSH          8'h06
`define SPSPS_OP_GET_RX_COUNT   8'h07
`define SPSPS_OP_GET_TX_COUNT   8'h08

// ==========================================================================
// Status byte bit positions
// ==========================================================================
`define SPSPS_ST_REJ_BIT        0
`define SPSPS_ST_OPN_BIT        1
`define SPSPS_ST_FRM_BIT        2
`define SPSPS_ST_PAR_BIT        3
`define SPSPS_ST_OVR_BIT        4

// ==========================================================================
// Mode fields and reset values
// ==========================================================================
`define SPSPS_LT_MSB            7
`define SPSPS_LT_LSB            6
`define SPSPS_LT_HALF_DUPLEX    2'b10
`define SPSPS_LT_SWITCHED_FULL  2'b11
`define SPSPS_ATTRIB_RESET      8'h00
`define SPSPS_LEDS_RESET        8'h04
`define SPSPS_CLKDIV_RESET      16'h0018

// ==========================================================================
// Buffer sizing
// ==========================================================================
`define SPSPS_FIFO_DEPTH        32
`define SPSPS_FIFO_AW           5
`define SPSPS_TX_READY_LIMIT    6'd30

`endif

// ===== spsps_uart_model.sv
`timescale 1ns/10ps
// ======================================
// Serial far end: shifts each character out, echoes it back
module spsps_uart_model #(
  parameter [7:0] BITS = 8'd6
) (
  input  wire       clk_in,
  input  wire       rst_n_in,
  input  wire       tx_valid_in,
  input  wire [7:0] tx_data_in,
  output wire       tx_ready_out,
  output reg        tx_busy_out,
  output reg        rx_valid_out,
  output reg  [7:0] rx_data_out
);
  reg [7:0] cnt_q;
  reg [7:0] sh_q;
  // Ready only between characters, like a real shifter
  assign tx_ready_out = rst_n_in && !tx_busy_out;
  // Echo lands while still busy; otherwise the line shows junk
  always @(posedge clk_in) begin
    rx_valid_out <= cnt_q == 8'd2;
    rx_data_out <= (cnt_q == 8'd2) ? sh_q : ~rx_data_out;
    if (!rst_n_in) begin
      cnt_q <= 8'd0;
      tx_busy_out <= 1'b0;
    end else if (tx_valid_in && tx_ready_out) begin
      cnt_q <= BITS;
      sh_q <= tx_data_in;
      tx_busy_out <= 1'b1;
    end else if (cnt_q != 8'd0) begin
      cnt_q <= cnt_q - 8'd1;
      tx_busy_out <= cnt_q != 8'd1;
    end
  end
endmodule // spsps_uart_model

// ===== testbench.sv
`timescale 1ns/10ps
// ======================================
// Bench plays the network client
module testbench;
  localparam [15:0] P0 = 16'd10001;
  reg         clk, rst_n, pv, pl, rr, xf, xp;
  reg  [7:0]  pd;
  reg  [15:0] dpt, spt;
  reg  [31:0] sip, lf;
  wire        prdy, rv, rlast, tv, trdy, tbusy, xv;
  wire [7:0]  rd, td, xd, attr;
  wire [15:0] rport, div;
  wire [31:0] rip;
  reg  [7:0]  cb [0:31];
  reg  [7:0]  rb [0:63];
  int         rn, error_cnt, checks_done, cyc, k;
  spsps_chan uut (.ref_clk_in(clk), .rst_n_in(rst_n), .pkt_valid_in(pv), .pkt_ready_out(prdy),
    .pkt_data_in(pd), .pkt_last_in(pl), .pkt_dst_port_in(dpt), .pkt_src_ip_in(sip),
    .pkt_src_port_in(spt), .resp_valid_out(rv), .resp_ready_in(rr), .resp_data_out(rd),
    .resp_last_out(rlast), .resp_dst_ip_out(rip), .resp_dst_port_out(rport),
    .rx_char_valid_in(xv), .rx_char_in(xd), .rx_frame_err_in(xf), .rx_parity_err_in(xp),
    .rx_uart_overrun_in(1'b0), .tx_busy_in(tbusy), .tx_char_valid_out(tv),
    .tx_char_ready_in(trdy), .tx_char_out(td), .tx_driver_en_out(), .rx_enable_out(),
    .port_open_out(), .status_out(), .mode_clock_div_out(div), .mode_attrib_out(attr),
    .mode_leds_out());
  spsps_uart_model u_uart (.clk_in(clk), .rst_n_in(rst_n), .tx_valid_in(tv), .tx_data_in(td),
    .tx_ready_out(trdy), .tx_busy_out(tbusy), .rx_valid_out(xv), .rx_data_out(xd));
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  // Hang guard well above the expected run length
  always @(posedge clk) if (++cyc == 20000) begin
    error_cnt++;
    test_done;
  end
  function [31:0] nx(input [31:0] v);
    nx = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function [7:0] stb(input command_rejected_flag, input port_open_flag, input [2:0] err);
    stb = {3'b000, err, port_open_flag, command_rejected_flag};
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Offer a packet while the sink stalls at random; en<0 skips the length check
  task automatic run(input int n, input [15:0] dp, input [7:0] es, input int en);
    int i, w;
    i = 0; w = 0; rn = 0; sip = lf; spt = lf[31:16]; dpt = dp;
    while (w < 200) begin
      pv = i < n; pd = cb[i]; pl = i == n - 1; rr = lf[0] | lf[1]; lf = nx(lf);
      if (pv && prdy) i++;
      if (rv && rr) begin
        rb[rn] = rd;
        rn++;
        if (rlast) w = 200;
      end
      if (i == n) w++;
      @(posedge clk);
      #1;
    end
    pv = 0;
    if (en >= 0) chk(rn, en);
    if (en != 0) chk(rb[0], es);
    if (en != 0) chk(rip, sip);
    if (en != 0) chk(rport, spt);
  endtask
  task snd(input [7:0] es);
    cb[0] = 8'h01;
    cb[1] = lf[7:0];
    run(2, P0, es, -1);
    idle(20);
  endtask
  task task_cnt(input [7:0] es, input [7:0] n);
    cb[0] = 8'h07;
    run(3, P0, es, 3);
    chk(rb[1], n);
  endtask
  task test_done;
    if (error_cnt == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    {rst_n, pv, pl, rr, xf, xp, pd, dpt, spt, sip, cyc, error_cnt, checks_done} = 0;
    lf = 32'hf149;
    idle(12);
    rst_n = 1;
    task_cnt(stb(0, 0, 0), 0);
    snd(stb(1, 0, 0));
    for (k = 0; k < 4; k++) begin
      cb[0] = 8'h09 | lf[7:0];
      run(1, P0, stb(1, 0, 0), 1);
    end
    cb[0] = 8'h04;
    run(1, P0, stb(0, 1, 0), 1);
    cb[0] = 8'h07;
    run(1, P0 + 16'd1, 0, 0);
    // Walk all line types; half duplex must swallow its own echo
    for (k = 0; k < 4; k++) begin
      cb[0] = 8'h00; cb[1] = lf[7:0]; cb[2] = 8'h00; cb[3] = {k[1:0], 6'h03}; cb[4] = 8'h04;
      run(5, P0, stb(0, 1, 0), 1);
      chk({attr, div}, {cb[3], cb[2], cb[1]});
      snd(stb(0, 1, 0));
    end
    task_cnt(stb(0, 1, 0), 3);
    cb[0] = 8'h00;
    cb[3] = 8'h40;
    run(4, P0, stb(1, 1, 0), 1);
    chk(attr, 8'hc3);
    xf = 1;
    snd(stb(0, 1, 0));
    xf = 0;
    xp = 1;
    snd(stb(0, 1, 1));
    xp = 0;
    task_cnt(stb(0, 1, 3), 3);
    cb[0] = 8'h03;
    run(1, P0, stb(0, 1, 0), 1);
    cb[0] = 8'h01;
    for (k = 1; k < 31; k++) begin
      cb[k] = lf[7:0];
      lf = nx(lf);
    end
    run(31, P0, stb(0, 1, 0), -1);
    idle(400);
    task_cnt(stb(0, 1, 4), 8'h20);
    // Drain: three old echoes, then the first 29 sent bytes; the 30th was lost
    cb[0] = 8'h02;
    run(1, P0, stb(0, 1, 4), 34);
    chk(rb[1], 8'h20);
    for (k = 0; k < 29; k++) chk(rb[k + 5], cb[k + 1]);
    snd(stb(0, 1, 4));
    task_cnt(stb(0, 1, 4), 1);
    cb[0] = 8'h06;
    run(1, P0, stb(0, 1, 4), 1);
    task_cnt(stb(0, 1, 4), 0);
    cb[0] = 8'h08;
    run(3, P0, stb(0, 1, 4), 3);
    chk(rb[1], 0);
    cb[0] = 8'h05;
    run(1, P0, stb(0, 0, 4), 1);
    test_done;
  end
endmodule // testbench
